// [src/gpio_port_pkg.sv]
/*
  constants for the eight-pin general-purpose port: register offsets,
  reset values, field positions and the filter timing.
  assumes a 10 MHz system clock and a 16-bit register port.
*/
package gpio_port_pkg;
  localparam int unsigned NPINS = 8;
  localparam int unsigned AW    = 12;
  localparam logic [AW-1:0] OFF_DATA     = 12'h200;
  localparam logic [AW-1:0] OFF_DIR      = 12'h202;
  localparam logic [AW-1:0] OFF_PULL     = 12'h204;
  localparam logic [AW-1:0] OFF_FLAGS    = 12'h206;
  localparam logic [AW-1:0] OFF_IRQCTL   = 12'h208;
  localparam logic [AW-1:0] OFF_DEBOUNCE = 12'h20a;
  localparam logic [AW-1:0] OFF_MODE     = 12'h20c;
  localparam logic [AW-1:0] OFF_FUNC     = 12'h20e;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 12'h210;
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned FILTER_NS  = 400;
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
endpackage : gpio_port_pkg

// [src/pin_debounce.sv]
/*
  per-pin chattering filter: the output follows the input only after
  it has stood still for a fixed count. assumes a synchronised input.
*/
module pin_debounce (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic in_i,
  output logic      out_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       out_r;
  logic       out_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (in_i == out_r) begin
      cnt_nxt = 4'h0;
    end else if (cnt_r == 4'(gpio_port_pkg::FILTER_CYC - 1)) begin
      cnt_nxt = 4'h0;
      out_nxt = in_i;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 4'h0;
      out_r <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign out_o = out_r;
endmodule : pin_debounce

// [src/gpio_port.sv]
/*
  eight-pin general-purpose port with register port, edge interrupts,
  per-pin debounce, pulls and peripheral hand-over.
  assumes pad inputs are asynchronous; peripheral signals share clk_i.
*/
// The strobed register port is this design's own decision.
module gpio_port (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic [7:0]  pad_in_i,
  output logic      [7:0]  pad_out_o,
  output logic      [7:0]  pad_oe_o,
  output logic      [7:0]  pull_en_o,
  output logic      [7:0]  pull_up_o,
  input  wire logic [7:0]  periph_out_i,
  input  wire logic [7:0]  periph_oe_i,
  output logic      [7:0]  periph_in_o,
  output logic      [15:0] pin_function_choice_o,
  output logic             irq_o
);
  localparam int unsigned N = gpio_port_pkg::NPINS;
  localparam int unsigned H = gpio_port_pkg::HI_LSB;

  logic [7:0]  pin_out_value_r, pin_out_value_nxt;
  logic [7:0]  input_enable_bits_r, input_enable_bits_nxt;
  logic [7:0]  output_enable_bits_r, output_enable_bits_nxt;
  logic [7:0]  pull_direction_select_r, pull_direction_select_nxt;
  logic [7:0]  pull_enable_bits_r, pull_enable_bits_nxt;
  logic [7:0]  pin_irq_flags_r, pin_irq_flags_nxt;
  logic [7:0]  irq_edge_select_r, irq_edge_select_nxt;
  logic [7:0]  pin_irq_enable_r, pin_irq_enable_nxt;
  logic [7:0]  debounce_enable_bits_r, debounce_enable_bits_nxt;
  logic [7:0]  peripheral_mode_bits_r, peripheral_mode_bits_nxt;
  logic [15:0] pin_function_choice_r, pin_function_choice_nxt;
  logic [7:0]  irq_mask_r, irq_mask_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  logic [7:0] s1_r, s2_r, s3_r;
  logic [7:0] stable_r, stable_nxt;
  logic [7:0] filt;
  logic [7:0] clean;
  logic [7:0] gated_r, gated_nxt;
  logic [7:0] edge_hit;
  logic [7:0] readback;

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r     <= 8'h00;
      s2_r     <= 8'h00;
      s3_r     <= 8'h00;
      stable_r <= 8'h00;
      gated_r  <= 8'h00;
    end else if (ce_i) begin
      s1_r     <= pad_in_i;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      stable_r <= stable_nxt;
      gated_r  <= gated_nxt;
    end
  end

  always_comb begin
    stable_nxt = stable_r;
    for (int i = 0; i < N; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        stable_nxt[i] = s3_r[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      pin_debounce u_deb (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .in_i    (stable_r[g]),
        .out_o   (filt[g])
      );
      // filter bypassed when its enable is clear
      assign clean[g] = debounce_enable_bits_r[g] ? filt[g]
                                                  : stable_r[g];
    end
  endgenerate

  // disabled input reads as 0 internally
  assign gated_nxt = clean & input_enable_bits_r;

  // rising when select is 0, falling when 1
  assign edge_hit = ((~irq_edge_select_r & gated_nxt & ~gated_r)
                    | (irq_edge_select_r & ~gated_nxt & gated_r))
                    & pin_irq_enable_r & ~peripheral_mode_bits_r;

  // peripheral pins hide their level from readback
  // live enable too: the gated stage lags one cycle after a disable
  assign readback = gated_r & input_enable_bits_r
                    & ~peripheral_mode_bits_r;

  // pad drive: gpio data or the peripheral's own signals
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (peripheral_mode_bits_r[i]) begin
        pad_out_o[i] = periph_out_i[i];
        pad_oe_o[i]  = periph_oe_i[i];
        pull_en_o[i] = 1'b0;
      end else begin
        pad_out_o[i] = pin_out_value_r[i];
        pad_oe_o[i]  = output_enable_bits_r[i];
        pull_en_o[i] = pull_enable_bits_r[i]
                       & ~output_enable_bits_r[i];
      end
    end
  end

  assign pull_up_o   = pull_direction_select_r;
  // peripherals see the synchronised level regardless of gpio input gating
  assign periph_in_o = stable_r & peripheral_mode_bits_r;
  assign pin_function_choice_o = pin_function_choice_r;

  // register next values
  always_comb begin
    pin_out_value_nxt         = pin_out_value_r;
    input_enable_bits_nxt     = input_enable_bits_r;
    output_enable_bits_nxt    = output_enable_bits_r;
    pull_direction_select_nxt = pull_direction_select_r;
    pull_enable_bits_nxt      = pull_enable_bits_r;
    irq_edge_select_nxt       = irq_edge_select_r;
    pin_irq_enable_nxt        = pin_irq_enable_r;
    debounce_enable_bits_nxt  = debounce_enable_bits_r;
    peripheral_mode_bits_nxt  = peripheral_mode_bits_r;
    pin_function_choice_nxt   = pin_function_choice_r;
    irq_mask_nxt              = irq_mask_r;
    pin_irq_flags_nxt         = pin_irq_flags_r;
    rdata_nxt                 = 16'h0000;
    if (wr_i) begin
      if (hit(addr_i, gpio_port_pkg::OFF_DATA)) begin
        pin_out_value_nxt = wdata_i[H +: 8];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_DIR)) begin
        input_enable_bits_nxt  = wdata_i[H +: 8];
        output_enable_bits_nxt = wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_PULL)) begin
        pull_direction_select_nxt = wdata_i[H +: 8];
        pull_enable_bits_nxt      = wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_FLAGS)) begin
        pin_irq_flags_nxt = pin_irq_flags_r & ~wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_IRQCTL)) begin
        irq_edge_select_nxt = wdata_i[H +: 8];
        pin_irq_enable_nxt  = wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_DEBOUNCE)) begin
        debounce_enable_bits_nxt = wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_MODE)) begin
        peripheral_mode_bits_nxt = wdata_i[7:0];
      end
      if (hit(addr_i, gpio_port_pkg::OFF_FUNC)) begin
        pin_function_choice_nxt = wdata_i;
      end
      if (hit(addr_i, gpio_port_pkg::OFF_IRQ_MASK)) begin
        irq_mask_nxt = wdata_i[7:0];
      end
    end
    // a read of the flag register also clears what it returned
    if (rd_i && hit(addr_i, gpio_port_pkg::OFF_FLAGS)) begin
      pin_irq_flags_nxt = pin_irq_flags_r & ~pin_irq_flags_r;
    end
    // new edges win over any clear in the same cycle
    pin_irq_flags_nxt = pin_irq_flags_nxt | edge_hit;
    if (rd_i) begin
      case (1'b1)
        hit(addr_i, gpio_port_pkg::OFF_DATA):
          rdata_nxt = {pin_out_value_r, readback};
        hit(addr_i, gpio_port_pkg::OFF_DIR):
          rdata_nxt = {input_enable_bits_r, output_enable_bits_r};
        hit(addr_i, gpio_port_pkg::OFF_PULL):
          rdata_nxt = {pull_direction_select_r, pull_enable_bits_r};
        hit(addr_i, gpio_port_pkg::OFF_FLAGS):
          rdata_nxt = {8'h00, pin_irq_flags_r};
        hit(addr_i, gpio_port_pkg::OFF_IRQCTL):
          rdata_nxt = {irq_edge_select_r, pin_irq_enable_r};
        hit(addr_i, gpio_port_pkg::OFF_DEBOUNCE):
          rdata_nxt = {8'h00, debounce_enable_bits_r};
        hit(addr_i, gpio_port_pkg::OFF_MODE):
          rdata_nxt = {8'h00, peripheral_mode_bits_r};
        hit(addr_i, gpio_port_pkg::OFF_FUNC):
          rdata_nxt = pin_function_choice_r;
        hit(addr_i, gpio_port_pkg::OFF_IRQ_MASK):
          rdata_nxt = {8'h00, irq_mask_r};
        default:
          rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_value_r         <= 8'h00;
      input_enable_bits_r     <= 8'h00;
      output_enable_bits_r    <= 8'h00;
      pull_direction_select_r <= 8'h00;
      pull_enable_bits_r      <= 8'h00;
      pin_irq_flags_r         <= 8'h00;
      irq_edge_select_r       <= 8'h00;
      pin_irq_enable_r        <= 8'h00;
      debounce_enable_bits_r  <= 8'h00;
      peripheral_mode_bits_r  <= 8'h00;
      pin_function_choice_r   <= gpio_port_pkg::RST_REG;
      irq_mask_r              <= 8'h00;
      rdata_r                 <= gpio_port_pkg::RST_REG;
    end else if (ce_i) begin
      pin_out_value_r         <= pin_out_value_nxt;
      input_enable_bits_r     <= input_enable_bits_nxt;
      output_enable_bits_r    <= output_enable_bits_nxt;
      pull_direction_select_r <= pull_direction_select_nxt;
      pull_enable_bits_r      <= pull_enable_bits_nxt;
      pin_irq_flags_r         <= pin_irq_flags_nxt;
      irq_edge_select_r       <= irq_edge_select_nxt;
      pin_irq_enable_r        <= pin_irq_enable_nxt;
      debounce_enable_bits_r  <= debounce_enable_bits_nxt;
      peripheral_mode_bits_r  <= peripheral_mode_bits_nxt;
      pin_function_choice_r   <= pin_function_choice_nxt;
      irq_mask_r              <= irq_mask_nxt;
      rdata_r                 <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_o   = |(pin_irq_flags_r & irq_mask_r);

  property p_drive_gpio;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!peripheral_mode_bits_r[0] && output_enable_bits_r[0])
        |-> (pad_out_o[0] == pin_out_value_r[0] && pad_oe_o[0]);
  endproperty
  a_drive_gpio: assert property (p_drive_gpio)
    else $error("gpio pin not driven with its data");

  property p_hiz_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!peripheral_mode_bits_r[0] && !output_enable_bits_r[0])
        |-> !pad_oe_o[0];
  endproperty
  a_hiz_off: assert property (p_hiz_off)
    else $error("pin driven while output disabled");

  property p_periph_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
      peripheral_mode_bits_r[1] |-> (pad_out_o[1] == periph_out_i[1]);
  endproperty
  a_periph_drive: assert property (p_periph_drive)
    else $error("peripheral pin follows gpio data");

  property p_in_off_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && addr_i == gpio_port_pkg::OFF_DATA
       && !input_enable_bits_r[2] && !input_enable_bits_nxt[2])
        |=> !rdata_o[2];
  endproperty
  a_in_off_zero: assert property (p_in_off_zero)
    else $error("disabled input read as 1");

  property p_periph_hidden;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && addr_i == gpio_port_pkg::OFF_DATA
       && peripheral_mode_bits_r[3]) |=> !rdata_o[3];
  endproperty
  a_periph_hidden: assert property (p_periph_hidden)
    else $error("peripheral pin level shown in readback");

  property p_w1c;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && wr_i && addr_i == gpio_port_pkg::OFF_FLAGS
       && wdata_i[0] && !edge_hit[0]) |=> !pin_irq_flags_r[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by write of 1");

  property p_edge_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && edge_hit[4]) |=> pin_irq_flags_r[4];
  endproperty
  a_edge_sets: assert property (p_edge_sets)
    else $error("edge did not set flag");

  property p_no_enable;
    @(posedge clk_i) disable iff (!rst_n_i)
      !pin_irq_enable_r[5] |-> !edge_hit[5];
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("disabled pin raised interrupt");

  property p_pull_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      output_enable_bits_r[6] |-> !pull_en_o[6];
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pull active with output enabled");

  property p_out_reg;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && wr_i && addr_i == gpio_port_pkg::OFF_DATA)
        |=> (pin_out_value_r == $past(wdata_i[15:8]));
  endproperty
  a_out_reg: assert property (p_out_reg)
    else $error("output data byte not stored");

  property p_bypass;
    @(posedge clk_i) disable iff (!rst_n_i)
      !debounce_enable_bits_r[7] |-> (clean[7] == stable_r[7]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("filter not bypassed");

  property p_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
      !peripheral_mode_bits_r[7] |-> (pad_oe_o[7] == output_enable_bits_r[7]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("gpio pin not under gpio control");

  property p_read_level;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && rd_i && addr_i == gpio_port_pkg::OFF_DATA)
        |=> (rdata_o[7:0] == $past(readback));
  endproperty
  a_read_level: assert property (p_read_level)
    else $error("readback mismatch");
endmodule : gpio_port

// [bench/pin_world.sv]
/*
  behavioural pin world for the eight-pin port: each pad level comes
  from the port drive, an outside driver, the pulls or a floating pad.
  assumes the bench owns the outside driver and that clk_i is shared.
*/
module pin_world (
  input  wire logic       clk_i,
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic [7:0] pull_en_i,
  input  wire logic [7:0] pull_up_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_lvl_i,
  output logic      [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // an open pad toggles so it never passes for a steady level
  logic [7:0] float_r = 8'h55;

  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end

  // outside driver yields to the port; bench avoids contention
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) begin
        pad_o[i] = pad_out_i[i];
      end else if (ext_en_i[i]) begin
        pad_o[i] = ext_lvl_i[i];
      end else if (pull_en_i[i]) begin
        pad_o[i] = pull_up_i[i];
      end else begin
        pad_o[i] = float_r[i];
      end
    end
  end
endmodule : pin_world

// [bench/eight_pin_gpio_port_test.sv]
/*
  self-checking bench for the eight-pin port: register port, pins,
  pulls, peripheral hand-over, edge interrupts and debounce.
  assumes the pin world model and a 10 MHz clock.
*/
module eight_pin_gpio_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0]  pad_in_i;
  logic [7:0]  pad_out_o;
  logic [7:0]  pad_oe_o;
  logic [7:0]  pull_en_o;
  logic [7:0]  pull_up_o;
  logic [7:0]  periph_out_i = 8'h00;
  logic [7:0]  periph_oe_i = 8'hff;
  logic [7:0]  periph_in_o;
  logic [15:0] pin_function_choice_o;
  logic        irq_o;
  logic [7:0]  ext_en_r = 8'h00;
  logic [7:0]  ext_lvl_r = 8'h00;
  logic        rd_pend_r = 1'b0;
  logic [15:0] exp_q[$];
  logic [7:0]  dout;
  logic [7:0]  pv;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  gpio_port dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pull_en_o(pull_en_o), .pull_up_o(pull_up_o),
    .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
    .periph_in_o(periph_in_o),
    .pin_function_choice_o(pin_function_choice_o), .irq_o(irq_o)
  );

  pin_world world (
    .clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .pull_en_i(pull_en_o), .pull_up_i(pull_up_o), .ext_en_i(ext_en_r),
    .ext_lvl_i(ext_lvl_r), .pad_o(pad_in_i)
  );

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_reg(input logic [15:0] act, input logic [15:0] exp);
    compares++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t read %h want %h", $time, act, exp);
    end
  endtask : check_reg

  // called on an edge: sees the values settled in the cycle before it
  task automatic check_pin(input logic [15:0] act, input logic [15:0] exp);
    compares++;
    if (act !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t pins %h want %h", $time, act, exp);
    end
  endtask : check_pin

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk_i);
    rd_i   <= 1'b0;
  endtask : rd

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic pins(input logic [7:0] v);
    @(posedge clk_i);
    ext_lvl_r <= v;
  endtask : pins

  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_pend_r) begin
      check_reg(rdata_o, exp_q.pop_front());
    end
    rd_pend_r <= rd_i && ce_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("CHECK FAILED %0t run hung", $time);
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h82f8));
    dout = 8'($urandom());
    pv   = 8'($urandom());
    step(3);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(gpio_port_pkg::OFF_DATA + 12'(2 * i), 16'h0000);
    end
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(gpio_port_pkg::OFF_DATA, 16'hff00);
    ce_i <= 1'b1;
    rd(gpio_port_pkg::OFF_DATA, 16'h0000);
    wr(gpio_port_pkg::OFF_DATA, {dout, 8'h5a});
    step(1);
    check_pin(pad_oe_o, 8'h00);
    rd(gpio_port_pkg::OFF_DATA, {dout, 8'h00});
    wr(gpio_port_pkg::OFF_DIR, 16'hffff);
    step(6);
    check_pin(pad_out_o, dout);
    check_pin(pad_oe_o, 8'hff);
    rd(gpio_port_pkg::OFF_DATA, {dout, dout});
    wr(gpio_port_pkg::OFF_DIR, 16'h00ff);
    step(6);
    rd(gpio_port_pkg::OFF_DATA, {dout, 8'h00});
    wr(gpio_port_pkg::OFF_DIR, 16'hffff);
    @(posedge clk_i);
    periph_out_i <= pv;
    wr(gpio_port_pkg::OFF_MODE, 16'h000f);
    step(6);
    check_pin(pad_out_o, {dout[7:4], pv[3:0]});
    check_pin(periph_in_o, {4'h0, pv[3:0]});
    rd(gpio_port_pkg::OFF_DATA, {dout, dout[7:4], 4'h0});
    wr(gpio_port_pkg::OFF_MODE, 16'h0000);
    wr(gpio_port_pkg::OFF_FUNC, 16'he41b);
    step(1);
    check_pin(pin_function_choice_o, 16'he41b);
    // pulls only while the output stays off
    wr(gpio_port_pkg::OFF_DIR, 16'hff00);
    wr(gpio_port_pkg::OFF_PULL, 16'hf0ff);
    step(6);
    check_pin(pull_en_o, 8'hff);
    check_pin(pull_up_o, 8'hf0);
    rd(gpio_port_pkg::OFF_DATA, {dout, 8'hf0});
    wr(gpio_port_pkg::OFF_DIR, 16'hff0f);
    step(1);
    check_pin(pull_en_o, 8'hf0);
    wr(gpio_port_pkg::OFF_PULL, 16'h0000);
    // edges: pins 3:0 falling, 7:4 rising
    @(posedge clk_i);
    ext_en_r <= 8'hff;
    wr(gpio_port_pkg::OFF_DIR, 16'hff00);
    wr(gpio_port_pkg::OFF_IRQCTL, 16'h0f00);
    wr(gpio_port_pkg::OFF_IRQ_MASK, 16'h00ff);
    pins(8'hff);
    step(8);
    pins(8'h00);
    step(10);
    check_pin(irq_o, 1'b0);
    wr(gpio_port_pkg::OFF_FLAGS, 16'h00ff);
    wr(gpio_port_pkg::OFF_IRQCTL, 16'h0fff);
    pins(8'h0f);
    step(10);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h0000);
    pins(8'hf0);
    step(10);
    check_pin(irq_o, 1'b1);
    wr(gpio_port_pkg::OFF_FLAGS, 16'h000f);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h00f0);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h0000);
    check_pin(irq_o, 1'b0);
    pins(8'h70);
    step(10);
    wr(gpio_port_pkg::OFF_FLAGS, 16'h00ff);
    wr(gpio_port_pkg::OFF_IRQ_MASK, 16'h007f);
    pins(8'hf0);
    step(10);
    check_pin(irq_o, 1'b0);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h0080);
    // a short pulse passes only the bypassed pin
    wr(gpio_port_pkg::OFF_DEBOUNCE, 16'h0001);
    pins(8'hf3);
    step(3);
    ext_lvl_r <= 8'hf0;
    step(15);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h0002);
    pins(8'hf1);
    step(10);
    pins(8'hf0);
    step(15);
    rd(gpio_port_pkg::OFF_FLAGS, 16'h0001);
    step(3);
    stop_test();
  end
endmodule : eight_pin_gpio_port_test
